/* File: rtl/seq_sequencer.sv */
// Image parameter sequencer: position, repeat and step control
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module seq_sequencer (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    // Register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [31:0] RDATA,
    // Capture commands
    input  wire logic        BURST_CMD,
    input  wire logic        CONT_TX_ENABLE_CMD,
    input  wire logic        SINGLE_CMD,
    input  wire logic        INTEG_START,
    // Input lines
    input  wire logic        STEP_LINE,
    input  wire logic        RESTART_LINE,
    // Active parameter set
    output logic             SEQ_ACTIVE,
    output logic      [4:0]  SET_INDEX,
    output logic      [7:0]  SET_REPEAT
);
    localparam int PW = seq_pkg::POS_W;

    logic          step_sync;
    logic          restart_sync;
    logic          step_prev_reg;
    logic          step_prev_next;
    logic          restart_prev_reg;
    logic          restart_prev_next;

    logic          enable_reg;
    logic          enable_next;
    logic          wrap_reg;
    logic          wrap_next;
    logic [7:0]    mode_reg;
    logic [7:0]    mode_next;
    logic [PW-1:0] length_reg;
    logic [PW-1:0] length_next;
    logic [PW-1:0] sel_reg;
    logic [PW-1:0] sel_next;
    logic [PW-1:0] pos_reg;
    logic [PW-1:0] pos_next;
    logic [7:0]    rep_cnt_reg;
    logic [7:0]    rep_cnt_next;
    logic [31:0]   rdata_reg;
    logic [31:0]   rdata_next;
    logic [15:0]   entry_reg [seq_pkg::DEPTH];
    logic [15:0]   entry_next [seq_pkg::DEPTH];

    seq_sync u_step_sync (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .d_in    (STEP_LINE),
        .q_out   (step_sync)
    );

    seq_sync u_restart_sync (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .d_in    (RESTART_LINE),
        .q_out   (restart_sync)
    );

    // Decoded register writes, line edges, step and restart requests, current entry fields
    logic        wr_ctrl;
    logic        wr_step;
    logic        sw_advance;
    logic        sw_restart;
    logic        hw_edge;
    logic        hw_restart;
    logic        start_cmd;
    logic        restart_req;
    logic        step_req;
    seq_pkg::src_t src;
    logic [7:0]  cur_mode;
    logic [7:0]  cur_rep;
    logic [7:0]  rep_limit;
    logic [PW-1:0] last_pos;

    assign wr_ctrl    = WR_STB && ADDR == seq_pkg::OFF_CTRL;
    assign wr_step    = WR_STB && ADDR == seq_pkg::OFF_STEP;
    assign sw_advance = wr_step && WDATA[seq_pkg::STEP_ADVANCE];
    assign sw_restart = wr_step && WDATA[seq_pkg::STEP_RESTART];
    assign hw_edge    = step_sync && !step_prev_reg;
    assign hw_restart = restart_sync && !restart_prev_reg;
    assign start_cmd  = BURST_CMD || CONT_TX_ENABLE_CMD;
    assign last_pos   = length_reg - PW'(1);
    assign cur_mode   = entry_reg[pos_reg][seq_pkg::ENTRY_MODE_LSB +: 8];
    assign cur_rep    = entry_reg[pos_reg][seq_pkg::ENTRY_REP_LSB +: 8];
    assign rep_limit  = (cur_rep == 8'h00) ? 8'h01 : cur_rep;

    // Source select: per entry if set, else global; unknown means 0x80
    always_comb begin
        logic [7:0] m;
        m = (cur_mode != 8'h00) ? cur_mode : mode_reg;
        case (m)
            seq_pkg::MODE_EDGE:  src = seq_pkg::SRC_EDGE;
            seq_pkg::MODE_LEVEL: src = seq_pkg::SRC_LEVEL;
            default:             src = seq_pkg::SRC_INTEG;
        endcase
    end

    // Restart sources
    assign restart_req = start_cmd || SINGLE_CMD
                         || hw_restart || sw_restart;

    // Step sources; manual advance steps in every source mode
    always_comb begin
        case (src)
            seq_pkg::SRC_EDGE:
                step_req = hw_edge || sw_advance;
            seq_pkg::SRC_LEVEL:
                step_req = (INTEG_START && step_sync) || sw_advance;
            default:
                step_req = INTEG_START || sw_advance;
        endcase
    end

    // Position and repeat counter
    always_comb begin
        pos_next     = pos_reg;
        rep_cnt_next = rep_cnt_reg;
        if (!enable_reg || restart_req) begin
            pos_next     = '0;
            rep_cnt_next = 8'h00;
        end else if (step_req) begin
            if (rep_cnt_reg + 8'h01 < rep_limit) begin
                rep_cnt_next = rep_cnt_reg + 8'h01;
            end else if (pos_reg >= last_pos) begin
                rep_cnt_next = 8'h00;
                pos_next     = wrap_reg ? '0 : last_pos;
            end else begin
                rep_cnt_next = 8'h00;
                pos_next     = pos_reg + PW'(1);
            end
        end
    end

    // Register file and entry storage
    always_comb begin
        enable_next = enable_reg;
        wrap_next   = wrap_reg;
        mode_next   = mode_reg;
        length_next = length_reg;
        sel_next    = sel_reg;
        entry_next  = entry_reg;
        rdata_next  = 32'h0000_0000;
        if (wr_ctrl) begin
            enable_next = WDATA[seq_pkg::CTRL_ENABLE];
            wrap_next   = WDATA[seq_pkg::CTRL_WRAP];
            mode_next   = WDATA[seq_pkg::CTRL_MODE_LSB +: 8];
        end
        if (WR_STB && ADDR == seq_pkg::OFF_LENGTH) begin
            length_next = WDATA[PW-1:0];
        end
        if (WR_STB && ADDR == seq_pkg::OFF_ENTRY_SEL) begin
            sel_next = WDATA[PW-1:0];
        end
        if (WR_STB && ADDR == seq_pkg::OFF_ENTRY_DATA) begin
            entry_next[sel_reg] = WDATA[15:0];
            sel_next            = sel_reg + PW'(1);
        end
        // Dropping sequencing frees the storage
        if (wr_ctrl && enable_reg && !WDATA[seq_pkg::CTRL_ENABLE]) begin
            for (int i = 0; i < seq_pkg::DEPTH; i++) begin
                entry_next[i] = 16'h0000;
            end
        end
        if (RD_STB) begin
            case (ADDR)
                seq_pkg::OFF_CTRL:
                    rdata_next = {16'h0000, mode_reg, 6'h00,
                                  wrap_reg, enable_reg};
                seq_pkg::OFF_STEP:
                    rdata_next = {3'h0, pos_reg, 24'h000001};
                seq_pkg::OFF_LENGTH:
                    rdata_next = {27'h0, length_reg};
                seq_pkg::OFF_ENTRY_SEL:
                    rdata_next = {27'h0, sel_reg};
                seq_pkg::OFF_ENTRY_DATA:
                    rdata_next = {16'h0000, entry_reg[sel_reg]};
                seq_pkg::OFF_STATUS:
                    rdata_next = {16'h0000, rep_cnt_reg, 3'h0, pos_reg};
                default:
                    rdata_next = 32'h0000_0000;
            endcase
        end
    end

    assign step_prev_next    = step_sync;
    assign restart_prev_next = restart_sync;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            step_prev_reg    <= 1'b0;
            restart_prev_reg <= 1'b0;
            enable_reg       <= 1'b0;
            wrap_reg         <= 1'b0;
            mode_reg         <= seq_pkg::RESET_MODE;
            length_reg       <= seq_pkg::RESET_LENGTH;
            sel_reg          <= '0;
            pos_reg          <= '0;
            rep_cnt_reg      <= 8'h00;
            rdata_reg        <= 32'h0000_0000;
            for (int i = 0; i < seq_pkg::DEPTH; i++) begin
                entry_reg[i] <= 16'h0000;
            end
        end else begin
            step_prev_reg    <= step_prev_next;
            restart_prev_reg <= restart_prev_next;
            enable_reg       <= enable_next;
            wrap_reg         <= wrap_next;
            mode_reg         <= mode_next;
            length_reg       <= length_next;
            sel_reg          <= sel_next;
            pos_reg          <= pos_next;
            rep_cnt_reg      <= rep_cnt_next;
            rdata_reg        <= rdata_next;
            entry_reg        <= entry_next;
        end
    end

    assign RDATA      = rdata_reg;
    assign SEQ_ACTIVE = enable_reg;
    assign SET_INDEX  = pos_reg;
    assign SET_REPEAT = rep_cnt_reg;

    sequence s_start;
        enable_reg && (BURST_CMD || CONT_TX_ENABLE_CMD);
    endsequence

    a_start_rewind: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        s_start |=> pos_reg == '0 && rep_cnt_reg == 8'h00)
        else $error("start command did not rewind");

    a_single_rewind: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        SINGLE_CMD |=> pos_reg == '0)
        else $error("single capture did not rewind");

    a_sw_restart: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        sw_restart |=> SET_INDEX == '0)
        else $error("restart flag ignored");

    a_hold_last: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        enable_reg && !wrap_reg && !restart_req && length_reg != '0
        && pos_reg == last_pos |=> pos_reg == $past(pos_reg))
        else $error("last entry not held");

    a_wrap_first: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        enable_reg && wrap_reg && !restart_req && step_req
        && pos_reg == last_pos && rep_cnt_reg + 8'h01 >= rep_limit
        |=> pos_reg == '0)
        else $error("wrap did not return to first");

    a_repeat_hold: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        enable_reg && !restart_req && step_req
        && rep_cnt_reg + 8'h01 < rep_limit |=> $stable(pos_reg))
        else $error("entry left before repeat count");

    a_advance_one: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        enable_reg && !restart_req && sw_advance && rep_limit == 8'h01
        && pos_reg < last_pos |=> pos_reg == $past(pos_reg) + PW'(1))
        else $error("manual advance did not step once");

    a_pos_readback: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        RD_STB && ADDR == seq_pkg::OFF_STEP
        |=> RDATA[seq_pkg::STEP_POS_LSB +: PW] == $past(pos_reg))
        else $error("position readback wrong");

    a_edge_step: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        enable_reg && src == seq_pkg::SRC_EDGE && !hw_edge
        && !sw_advance && !restart_req |=> $stable(pos_reg))
        else $error("edge mode stepped without edge");
endmodule : seq_sequencer

/* File: rtl/seq_pkg.sv */
// Constants shared by the image parameter sequencer
package seq_pkg;
    localparam int          POS_W          = 5;
    localparam int          REP_W          = 8;
    localparam int          MODE_W         = 8;
    localparam int          DEPTH          = 32;
    // Register word offsets
    localparam logic [3:0]  OFF_CTRL       = 4'h0;
    localparam logic [3:0]  OFF_STEP       = 4'h1;
    localparam logic [3:0]  OFF_LENGTH     = 4'h2;
    localparam logic [3:0]  OFF_ENTRY_SEL  = 4'h3;
    localparam logic [3:0]  OFF_ENTRY_DATA = 4'h4;
    localparam logic [3:0]  OFF_STATUS     = 4'h5;
    // Control word fields
    localparam int          CTRL_ENABLE    = 0;
    localparam int          CTRL_WRAP      = 1;
    localparam int          CTRL_MODE_LSB  = 8;
    // Step word fields
    localparam int          STEP_ADVANCE   = 5;
    localparam int          STEP_RESTART   = 6;
    localparam int          STEP_POS_LSB   = 24;
    // Entry word fields
    localparam int          ENTRY_REP_LSB  = 0;
    localparam int          ENTRY_MODE_LSB = 8;
    // Step source codes
    localparam logic [7:0]  MODE_INTEG     = 8'h80;
    localparam logic [7:0]  MODE_EDGE      = 8'h82;
    localparam logic [7:0]  MODE_LEVEL     = 8'h84;
    localparam logic [7:0]  RESET_MODE     = 8'h80;
    localparam logic [4:0]  RESET_LENGTH   = 5'h00;
    typedef enum logic [1:0] {SRC_INTEG, SRC_EDGE, SRC_LEVEL} src_t;
endpackage : seq_pkg

/* File: rtl/seq_sync.sv */
// Two-flop synchroniser for an external input line
`timescale 1ns/1ps
module seq_sync (
    // Clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET_N,
    // Data
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = d_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign q_out = sync_reg;
endmodule : seq_sync

/* File: verif/image_parameter_sequencer_test.sv */
// Self-checking bench for the image parameter sequencer
`timescale 1ns/1ps
module image_parameter_sequencer_test;
    logic        sys_clk;
    logic        reset_n;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic [3:0]  cmd;
    logic        step_line;
    logic        restart_line;
    logic        seq_active;
    logic [4:0]  set_index;
    logic [7:0]  set_repeat;
    logic [31:0] rd_val;
    int          err_total;
    int          tests_run;

    seq_sequencer seq_sequencer_inst (
        .SYS_CLK            (sys_clk),
        .RESET_N            (reset_n),
        .ADDR               (addr),
        .WDATA              (wdata),
        .WR_STB             (wr_stb),
        .RD_STB             (rd_stb),
        .RDATA              (rdata),
        .BURST_CMD          (cmd[0]),
        .CONT_TX_ENABLE_CMD (cmd[1]),
        .SINGLE_CMD         (cmd[2]),
        .INTEG_START        (cmd[3]),
        .STEP_LINE          (step_line),
        .RESTART_LINE       (restart_line),
        .SEQ_ACTIVE         (seq_active),
        .SET_INDEX          (set_index),
        .SET_REPEAT         (set_repeat)
    );

    always #12.5 sys_clk = ~sys_clk;

    task print_verdict;
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : check

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : rd

    task pulse(input logic [3:0] m);
        @(posedge sys_clk);
        cmd <= m;
        @(posedge sys_clk);
        cmd <= 4'h0;
    endtask : pulse

    // Looks at the settled position, then hands back on a rising edge
    task idx(input logic [4:0] e);
        @(negedge sys_clk);
        check("SET_INDEX", {27'h0, set_index}, {27'h0, e});
        @(posedge sys_clk);
    endtask : idx

    task integ(input logic [4:0] e);
        pulse(4'h8);
        idx(e);
    endtask : integ

    task settle;
        repeat (5) @(posedge sys_clk);
    endtask : settle

    // Four entries, repeat counts 1, 2, 0, 1
    task load_list;
        wr(seq_pkg::OFF_LENGTH, 32'h00000004);
        wr(seq_pkg::OFF_ENTRY_SEL, 32'h00000000);
        wr(seq_pkg::OFF_ENTRY_DATA, 32'h00000001);
        wr(seq_pkg::OFF_ENTRY_DATA, 32'h00000002);
        wr(seq_pkg::OFF_ENTRY_DATA, 32'h00000000);
        wr(seq_pkg::OFF_ENTRY_DATA, 32'h00000001);
    endtask : load_list

    task t_reset;
        idx(5'h00);
        check("SEQ_ACTIVE", {31'h0, seq_active}, 32'h0);
        rd(seq_pkg::OFF_STEP);
        check("STEP presence", {31'h0, rd_val[0]}, 32'h1);
        rd(4'hf);
        check("unmapped read", rd_val, 32'h0);
    endtask : t_reset

    task t_integ;
        load_list();
        wr(seq_pkg::OFF_CTRL, 32'h00008001);
        pulse(4'h1);
        check("SEQ_ACTIVE", {31'h0, seq_active}, 32'h1);
        integ(5'h01);
        integ(5'h01);
        check("SET_REPEAT", {24'h0, set_repeat}, 32'h1);
        integ(5'h02);
        integ(5'h03);
        integ(5'h03);
        rd(seq_pkg::OFF_STEP);
        check("STEP position", {27'h0, rd_val[28:24]}, 32'h3);
        rd(seq_pkg::OFF_STATUS);
        check("STATUS position", {27'h0, rd_val[4:0]}, 32'h3);
    endtask : t_integ

    // Reissue burst, continuous and single commands in turn, each rewinding
    task t_rewind;
        logic [3:0] m;
        for (int i = 0; i < 3; i++) begin
            m = 4'h1 << i;
            pulse(m);
            idx(5'h00);
            integ(5'h01);
        end
    endtask : t_rewind

    task t_manual;
        wr(seq_pkg::OFF_CTRL, 32'h00008201);
        pulse(4'h1);
        wr(seq_pkg::OFF_STEP, 32'h00000020);
        idx(5'h01);
        wr(seq_pkg::OFF_STEP, 32'h00000020);
        idx(5'h01);
        wr(seq_pkg::OFF_STEP, 32'h00000020);
        idx(5'h02);
        integ(5'h02);
        step_line <= 1'b1;
        settle();
        idx(5'h03);
        step_line <= 1'b0;
        wr(seq_pkg::OFF_STEP, 32'h00000040);
        idx(5'h00);
        wr(seq_pkg::OFF_STEP, 32'h00000020);
        restart_line <= 1'b1;
        settle();
        idx(5'h00);
        restart_line <= 1'b0;
        settle();
    endtask : t_manual

    task t_level;
        wr(seq_pkg::OFF_CTRL, 32'h00008401);
        pulse(4'h1);
        step_line <= 1'b1;
        settle();
        integ(5'h01);
        integ(5'h01);
        integ(5'h02);
        step_line <= 1'b0;
        settle();
        integ(5'h02);
        wr(seq_pkg::OFF_CTRL, 32'h00008101);
        integ(5'h03);
    endtask : t_level

    task t_wrap;
        wr(seq_pkg::OFF_CTRL, 32'h00008003);
        pulse(4'h1);
        integ(5'h01);
        integ(5'h01);
        integ(5'h02);
        integ(5'h03);
        integ(5'h00);
    endtask : t_wrap

    task t_disable;
        wr(seq_pkg::OFF_CTRL, 32'h00008000);
        idx(5'h00);
        check("SEQ_ACTIVE", {31'h0, seq_active}, 32'h0);
        integ(5'h00);
        wr(seq_pkg::OFF_ENTRY_SEL, 32'h00000000);
        rd(seq_pkg::OFF_ENTRY_DATA);
        check("entry cleared", rd_val, 32'h0);
        load_list();
        // Entry 1 steps on line edges or manual advance only
        wr(seq_pkg::OFF_ENTRY_SEL, 32'h00000001);
        wr(seq_pkg::OFF_ENTRY_DATA, 32'h00008202);
        wr(seq_pkg::OFF_CTRL, 32'h00008001);
        pulse(4'h1);
        integ(5'h01);
        integ(5'h01);
        check("SET_REPEAT", {24'h0, set_repeat}, 32'h0);
    endtask : t_disable

    initial begin
        sys_clk      = 1'b0;
        reset_n      = 1'b0;
        addr         = 4'h0;
        wdata        = 32'h0;
        wr_stb       = 1'b0;
        rd_stb       = 1'b0;
        cmd          = 4'h0;
        step_line    = 1'b0;
        restart_line = 1'b0;
        err_total    = 0;
        tests_run    = 0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_integ();
        t_rewind();
        t_manual();
        t_level();
        t_wrap();
        t_disable();
        print_verdict();
    end

    // Whole run needs well under 1000 cycles
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
endmodule : image_parameter_sequencer_test
